// ---- src/pcg_pkg.sv ----
// Purpose: Shared constants and types of the pulse capture and guide sensor readout block.
// Assumes: 40 MHz clock, four pulse inputs, AXI4-Lite register access.
// Notes: All offsets are byte addresses of aligned 32-bit words.
package pcg_pkg;
  localparam int NUM_IN = 4;
  localparam int CLK_HZ = 40_000_000;
  localparam int US_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam int GATE_S = 1;
  localparam int GATE_CYCLES = GATE_S * CLK_HZ;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_WIDTH = 3'h1;
  localparam logic [2:0] MODE_FREQ = 3'h2;
  localparam logic [2:0] MODE_DUTY = 3'h3;
  localparam logic [2:0] MODE_COUNT = 3'h4;
  localparam logic [15:0] DUTY_FULL = 16'h0fff;
  localparam logic signed [15:0] CONV_LIMIT = 16'sh03e8;
  localparam int GAIN_SHIFT = 10;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CENTER = 8'h04;
  localparam logic [7:0] ADDR_RANGE = 8'h08;
  localparam logic [7:0] ADDR_GAIN = 8'h0c;
  localparam logic [7:0] ADDR_SELECT = 8'h10;
  localparam logic [7:0] ADDR_GSTATUS = 8'h14;
  localparam logic [7:0] ADDR_GTRACK = 8'h18;
  localparam logic [7:0] ADDR_GGYRO = 8'h1c;
  localparam logic [7:0] ADDR_GCROSS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h28;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h2c;
  localparam logic [7:0] ADDR_RAW0 = 8'h40;
  localparam logic [7:0] ADDR_CONV0 = 8'h60;
  localparam int CTRL_MULTI_BIT = 16;
  localparam int CTRL_GEN_LSB = 20;
  localparam int ST_CROSS = 0;
  localparam int ST_DETECT = 1;
  localparam int ST_LEFT = 2;
  localparam int ST_RIGHT = 3;
  localparam int ST_ACTIVE = 8;
  localparam int IRQ_W = NUM_IN + 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] GAIN_RESET = 16'h0400;
  localparam logic [15:0] MAX_RESET = 16'h07d0;
  localparam logic [15:0] MIN_RESET = 16'h03e8;
  localparam logic [15:0] CENTER_RESET = 16'h05dc;
  typedef enum logic {DIV_IDLE, DIV_RUN} pcg_div_t;
endpackage : pcg_pkg

// ---- src/pcg_capture_channel.sv ----
// Purpose: One pulse input measured as width, frequency, duty cycle or count.
// Assumes: Pulse input already synchronous to clk.
// Notes: Value is held until the next completed measurement and reads zero while disabled or in an unused mode.
`timescale 1ns/10ps
module pcg_capture_channel
  import pcg_pkg::*;
#(
  parameter int GATE = GATE_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pulseIn,
  input wire logic [2:0] mode,
  output logic [15:0] value,
  output logic update
);
  typedef struct packed {
    logic inPrev;
    logic [5:0] tick;
    logic [15:0] highUs;
    logic [15:0] periodUs;
    logic [15:0] lastHigh;
    logic [31:0] gate;
    logic [15:0] edges;
    pcg_div_t div;
    logic [16:0] rem;
    logic [11:0] numLo;
    logic [11:0] quot;
    logic [15:0] den;
    logic [3:0] step;
    logic [15:0] value;
    logic update;
  } pcg_chan_t;

  pcg_chan_t s, next_s;
  logic usTick, rise, fall;
  logic [27:0] num;
  logic [16:0] trial;

  function automatic logic [15:0] satInc(input logic [15:0] v);
    satInc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : satInc

  always_comb
  begin
    next_s = s;
    next_s.update = 1'b0;
    usTick = (s.tick == 6'(CYC_PER_US - 1));
    rise = pulseIn && !s.inPrev;
    fall = !pulseIn && s.inPrev;
    num = 28'(s.lastHigh) * 28'(DUTY_FULL);
    trial = {s.rem[15:0], s.numLo[11]};
    next_s.inPrev = pulseIn;
    next_s.tick = usTick ? 6'h00 : s.tick + 6'h01;
    if (usTick && pulseIn)
    begin
      next_s.highUs = satInc(s.highUs);
    end
    if (usTick)
    begin
      next_s.periodUs = satInc(s.periodUs);
    end
    if (fall)
    begin
      next_s.lastHigh = s.highUs;
      next_s.highUs = 16'h0000;
    end
    if (rise)
    begin
      // A tick in the rising cycle belongs to the new period, or the period reads one short.
      next_s.periodUs = {15'h0000, usTick};
    end
    unique case (mode)
      MODE_OFF:
      begin
        next_s.edges = 16'h0000;
        next_s.value = 16'h0000;
        next_s.gate = 32'h0;
      end
      MODE_WIDTH:
      begin
        if (fall)
        begin
          next_s.value = s.highUs;
          next_s.update = 1'b1;
        end
      end
      MODE_FREQ:
      begin
        next_s.gate = s.gate + 32'h1;
        if (rise)
        begin
          next_s.edges = satInc(s.edges);
        end
        if (s.gate == 32'(GATE - 1))
        begin
          next_s.gate = 32'h0;
          next_s.value = s.edges + {15'h0000, rise};
          next_s.edges = 16'h0000;
          next_s.update = 1'b1;
        end
      end
      MODE_DUTY:
      begin
        if (rise && s.div == DIV_IDLE && s.periodUs != 16'h0000)
        begin
          next_s.div = DIV_RUN;
          next_s.den = s.periodUs;
          next_s.rem = (s.lastHigh >= s.periodUs) ? 17'h1ffff : {1'b0, num[27:12]};
          next_s.numLo = num[11:0];
          next_s.step = 4'h0;
        end
        if (s.div == DIV_RUN)
        begin
          if (s.rem == 17'h1ffff)
          begin
            next_s.div = DIV_IDLE;
            next_s.value = DUTY_FULL;
            next_s.update = 1'b1;
          end
          else
          begin
            next_s.numLo = {s.numLo[10:0], 1'b0};
            next_s.rem = (trial >= {1'b0, s.den}) ? trial - {1'b0, s.den} : trial;
            next_s.quot = {s.quot[10:0], trial >= {1'b0, s.den}};
            next_s.step = s.step + 4'h1;
            if (s.step == 4'hb)
            begin
              next_s.div = DIV_IDLE;
              next_s.value = {4'h0, s.quot[10:0], trial >= {1'b0, s.den}};
              next_s.update = 1'b1;
            end
          end
        end
      end
      MODE_COUNT:
      begin
        if (rise)
        begin
          next_s.edges = satInc(s.edges);
          next_s.value = satInc(s.edges);
          next_s.update = 1'b1;
        end
      end
      default:
      begin
        next_s.value = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign value = s.value;
  assign update = s.update;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  count_no_decrement_a: assert property ((mode == MODE_COUNT && $past(mode) == MODE_COUNT) |-> value >= $past(value)) else $error("Pulse count went down.");
  count_clear_a: assert property (mode == MODE_OFF |=> value == 16'h0000) else $error("Count not cleared while disabled.");
  duty_range_a: assert property ((mode == MODE_DUTY && update) |-> value <= DUTY_FULL) else $error("Duty value above full scale.");
  width_on_fall_a: assert property ((mode == MODE_WIDTH && $past(mode) == MODE_WIDTH && update) |-> $past(s.inPrev) && !s.inPrev) else $error("Width updated away from falling edge.");
endmodule : pcg_capture_channel

// ---- src/pcg_top.sv ----
// Purpose: Pulse capture with converted values and guide sensor readout over AXI4-Lite.
// Assumes: Guide sensor fields arrive already decoded with a one-cycle valid per sensor.
// Notes: Queries read held copies, so a read never disturbs a measurement in progress.
// What this block does
// - Width mode reports captured high time in microseconds.
// - Frequency mode reports input frequency in hertz.
// - Duty mode scales 0% to 0 and 100% to 4095 linearly.
// - Count mode keeps a pulse count that only increments.
// - Count clears by switching to disabled then back to count; a frequency gate ending in between also restarts it.
// - Raw capture values read as unsigned 16-bit numbers.
// - Converted value is clamped to -1000..1000, zero when disabled.
// - Status: cross bit0, detect bit1, left bit2, right bit3, active bit8.
// - Single sensor needs no selection; multi-sensor mode selects by input number.
// - Single sensor: index 1 left, 2 right, 3 active track.
// - Multi-sensor: index (p-1)*3 plus 1..3 picks sensor p tracks.
// - Track positions are signed 16-bit millimetres from sensor centre.
// - Gyroscope value is signed 16-bit, -32768..32767.
// - Tape cross reads as a single bit, 0 or 1.
`timescale 1ns/10ps
module pcg_top
  import pcg_pkg::*;
#(
  parameter int GATE = GATE_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NUM_IN-1:0] pulseIn,
  input wire logic [NUM_IN-1:0] guideValid,
  input wire logic [NUM_IN-1:0] guideCross,
  input wire logic [NUM_IN-1:0] guideDetect,
  input wire logic [NUM_IN-1:0] guideLeftMark,
  input wire logic [NUM_IN-1:0] guideRightMark,
  input wire logic [NUM_IN*16-1:0] guideLeftPos,
  input wire logic [NUM_IN*16-1:0] guideRightPos,
  input wire logic [NUM_IN*16-1:0] guideActivePos,
  input wire logic [NUM_IN*16-1:0] guideGyro,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] center;
    logic [31:0] range;
    logic [31:0] gain;
    logic [31:0] select;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqEn;
    logic [NUM_IN-1:0][15:0] raw;
    logic [NUM_IN-1:0][15:0] conv;
    logic [NUM_IN-1:0][4:0] gFlags;
    logic [NUM_IN-1:0][15:0] gLeft;
    logic [NUM_IN-1:0][15:0] gRight;
    logic [NUM_IN-1:0][15:0] gAct;
    logic [NUM_IN-1:0][15:0] gGyro;
  } pcg_state_t;

  pcg_state_t s, next_s;
  logic [NUM_IN-1:0][15:0] chanValue;
  logic [NUM_IN-1:0] chanUpdate;
  logic [IRQ_W-1:0] events;
  logic [31:0] rd;
  logic rdOk;
  logic wrFire;
  logic [1:0] curSensor;
  logic [1:0] selSensor;
  logic selOk;
  logic [1:0] trkSensor;
  logic [1:0] trkElem;
  logic trkOk;

  for (genvar i = 0; i < NUM_IN; i++)
  begin : g_chan
    pcg_capture_channel #(
      .GATE(GATE)
    ) u_chan (
      .clk(clk),
      .sys_rst(sys_rst),
      .pulseIn(pulseIn[i]),
      .mode(s.ctrl[3*i +: 3]),
      .value(chanValue[i]),
      .update(chanUpdate[i])
    );
  end

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
    begin
      old[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
    end
    applyStrb = old;
  endfunction : applyStrb

  function automatic logic signed [15:0] convert(input logic [15:0] raw, input logic [31:0] center,
                                                  input logic [31:0] range, input logic [31:0] gain);
    logic [15:0] r;
    logic signed [17:0] d;
    logic signed [17:0] band;
    logic signed [35:0] p;
    r = raw;
    band = 18'(center[31:16]);
    if (r < range[15:0])
    begin
      r = range[15:0];
    end
    if (r > range[31:16])
    begin
      r = range[31:16];
    end
    d = $signed({2'b00, r}) - $signed({2'b00, center[15:0]});
    if (d <= band && d >= -band)
    begin
      d = 18'sh0;
    end
    else
    begin
      d = (d > 0) ? d - band : d + band;
    end
    p = (36'(d) * $signed({20'h00000, gain[15:0]})) >>> GAIN_SHIFT;
    if (p > 36'(CONV_LIMIT))
    begin
      p = 36'(CONV_LIMIT);
    end
    if (p < -36'(CONV_LIMIT))
    begin
      p = -36'(CONV_LIMIT);
    end
    convert = p[15:0];
  endfunction : convert

  always_comb
  begin
    // Single sensor is the lowest enabled input.
    curSensor = 2'h0;
    for (int i = NUM_IN - 1; i >= 0; i--)
    begin
      if (s.ctrl[CTRL_GEN_LSB + i])
      begin
        curSensor = 2'(i);
      end
    end
    if (s.ctrl[CTRL_MULTI_BIT])
    begin
      selSensor = 2'(s.select[7:0] - 8'h01);
      selOk = s.select[7:0] >= 8'h01 && s.select[7:0] <= 8'(NUM_IN);
    end
    else
    begin
      selSensor = curSensor;
      selOk = s.select[7:0] <= 8'h01;
    end
    trkSensor = curSensor;
    trkElem = 2'(s.select[15:8] - 8'h01);
    trkOk = s.select[15:8] >= 8'h01 && s.select[15:8] <= 8'h03;
    if (s.ctrl[CTRL_MULTI_BIT])
    begin
      // Index split into sensor and track.
      trkOk = s.select[15:8] >= 8'h01 && s.select[15:8] <= 8'(3 * NUM_IN);
      trkSensor = 2'((s.select[15:8] - 8'h01) / 8'h03);
      trkElem = 2'((s.select[15:8] - 8'h01) % 8'h03);
    end
    selOk = selOk && s.ctrl[CTRL_GEN_LSB + selSensor];
    trkOk = trkOk && s.ctrl[CTRL_GEN_LSB + trkSensor];
  end

  always_comb
  begin
    rdOk = 1'b1;
    rd = 32'h0;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd = s.ctrl;
      ADDR_CENTER: rd = s.center;
      ADDR_RANGE: rd = s.range;
      ADDR_GAIN: rd = s.gain;
      ADDR_SELECT: rd = s.select;
      ADDR_GSTATUS: rd = selOk ? {23'h0, s.gFlags[selSensor][4], 4'h0, s.gFlags[selSensor][3:0]} : 32'h0;
      ADDR_GTRACK:
      begin
        unique case (trkElem)
          2'h0: rd = {{16{s.gLeft[trkSensor][15]}}, s.gLeft[trkSensor]};
          2'h1: rd = {{16{s.gRight[trkSensor][15]}}, s.gRight[trkSensor]};
          default: rd = {{16{s.gAct[trkSensor][15]}}, s.gAct[trkSensor]};
        endcase
        rd = trkOk ? rd : 32'h0;
      end
      ADDR_GGYRO: rd = selOk ? {{16{s.gGyro[selSensor][15]}}, s.gGyro[selSensor]} : 32'h0;
      ADDR_GCROSS: rd = selOk ? {31'h0, s.gFlags[selSensor][ST_CROSS]} : 32'h0;
      ADDR_IRQ_STAT: rd = {{(32 - IRQ_W){1'b0}}, s.irqStat};
      ADDR_IRQ_CLR: rd = 32'h0;
      ADDR_IRQ_EN: rd = {{(32 - IRQ_W){1'b0}}, s.irqEn};
      default:
      begin
        rdOk = 1'b0;
        for (int i = 0; i < NUM_IN; i++)
        begin
          if (s_axi_araddr == ADDR_RAW0 + 8'(4 * i))
          begin
            rd = {16'h0000, s.raw[i]};
            rdOk = 1'b1;
          end
          if (s_axi_araddr == ADDR_CONV0 + 8'(4 * i))
          begin
            rd = {{16{s.conv[i][15]}}, s.conv[i]};
            rdOk = 1'b1;
          end
        end
      end
    endcase
  end

  assign wrFire = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_arready = !s.rvalid;

  always_comb
  begin
    next_s = s;
    events = '0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (chanUpdate[i])
      begin
        next_s.raw[i] = chanValue[i];
        next_s.conv[i] = convert(chanValue[i], s.center, s.range, s.gain);
        events[i] = 1'b1;
      end
      if (s.ctrl[3*i +: 3] == MODE_OFF)
      begin
        next_s.raw[i] = 16'h0000;
        next_s.conv[i] = 16'h0000;
      end
      if (!s.ctrl[CTRL_GEN_LSB + i])
      begin
        next_s.gFlags[i] = 5'h00;
      end
      else if (guideValid[i])
      begin
        next_s.gFlags[i] = {1'b1, guideRightMark[i], guideLeftMark[i], guideDetect[i], guideCross[i]};
        next_s.gLeft[i] = guideLeftPos[16*i +: 16];
        next_s.gRight[i] = guideRightPos[16*i +: 16];
        next_s.gAct[i] = guideActivePos[16*i +: 16];
        next_s.gGyro[i] = guideGyro[16*i +: 16];
        events[NUM_IN] = events[NUM_IN] || (guideCross[i] && !s.gFlags[i][ST_CROSS]);
      end
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.irqStat = s.irqStat | events;
    if (wrFire)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s_axi_awaddr)
        ADDR_CTRL: next_s.ctrl = applyStrb(s.ctrl, s_axi_wdata, s_axi_wstrb);
        ADDR_CENTER: next_s.center = applyStrb(s.center, s_axi_wdata, s_axi_wstrb);
        ADDR_RANGE: next_s.range = applyStrb(s.range, s_axi_wdata, s_axi_wstrb);
        ADDR_GAIN: next_s.gain = applyStrb(s.gain, s_axi_wdata, s_axi_wstrb);
        ADDR_SELECT: next_s.select = applyStrb(s.select, s_axi_wdata, s_axi_wstrb);
        ADDR_IRQ_EN: next_s.irqEn = IRQ_W'(applyStrb(32'h0, s_axi_wdata, s_axi_wstrb));
        // A new event in the clearing cycle stays set.
        ADDR_IRQ_CLR: next_s.irqStat = (s.irqStat & ~IRQ_W'(applyStrb(32'h0, s_axi_wdata, s_axi_wstrb))) | events;
        ADDR_GSTATUS, ADDR_GTRACK, ADDR_GGYRO, ADDR_GCROSS, ADDR_IRQ_STAT: next_s.bresp = RESP_OKAY;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.center <= {16'h0000, CENTER_RESET};
      s.range <= {MAX_RESET, MIN_RESET};
      s.gain <= {16'h0000, GAIN_RESET};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign irq = |(s.irqStat & s.irqEn);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  conv_range_a: assert property (chanUpdate[0] |=> $signed(s.conv[0]) <= CONV_LIMIT && $signed(s.conv[0]) >= -CONV_LIMIT) else $error("Converted value out of range.");
  conv_disabled_a: assert property (s.ctrl[2:0] == MODE_OFF |=> s.conv[0] == 16'h0000 && s.raw[0] == 16'h0000) else $error("Disabled input not zero.");
  raw_hold_a: assert property ((!chanUpdate[1] && s.ctrl[5:3] != MODE_OFF) |=> s.raw[1] == $past(s.raw[1])) else $error("Raw value changed without capture.");
  cross_bit_a: assert property ((s_axi_arvalid && !s.rvalid && s_axi_araddr == ADDR_GCROSS) |=> s.rdata[31:1] == 31'h0) else $error("Tape cross wider than one bit.");
  status_layout_a: assert property ((s_axi_arvalid && !s.rvalid && s_axi_araddr == ADDR_GSTATUS) |=> s.rdata[7:4] == 4'h0 && s.rdata[31:9] == 23'h0) else $error("Status reserved bits set.");
  bresp_hold_a: assert property ((s.bvalid && !s_axi_bready) |=> s.bvalid && $stable(s.bresp)) else $error("Write response dropped.");
  read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("Read not answered next cycle.");
  cover_write_c: cover property (wrFire ##[1:4] s_axi_bvalid && s_axi_bready);
  cover_irq_c: cover property (irq);
  cover_track_c: cover property (s.ctrl[CTRL_MULTI_BIT] && trkOk && trkSensor == 2'h1);
endmodule : pcg_top

// ---- sim/pcg_sensor_model.sv ----
// Purpose: Pulse sources and decoded guide sensors facing the block.
// Assumes: High and low times in clock cycles, 8 bits per input.
// Notes: Guide fields read inverted outside guideValid, so a stale sample shows.
`timescale 1ns/10ps
module pcg_sensor_model
  import pcg_pkg::*;
(
  input wire logic clk,
  input wire logic [NUM_IN*8-1:0] highCyc,
  input wire logic [NUM_IN*8-1:0] lowCyc,
  input wire logic [NUM_IN-1:0] crossIn,
  output logic [NUM_IN-1:0] pulseIn,
  output logic [NUM_IN-1:0] guideValid,
  output logic [NUM_IN-1:0] guideCross,
  output logic [NUM_IN-1:0] guideDetect,
  output logic [NUM_IN-1:0] guideLeftMark,
  output logic [NUM_IN-1:0] guideRightMark,
  output logic [NUM_IN*16-1:0] guideLeftPos,
  output logic [NUM_IN*16-1:0] guideRightPos,
  output logic [NUM_IN*16-1:0] guideActivePos,
  output logic [NUM_IN*16-1:0] guideGyro
);
  int cnt [NUM_IN] = '{default: 0};
  logic [3:0] tick = 4'h0;
  initial pulseIn = '0;
  always @(posedge clk)
  begin
    tick <= tick + 4'h1;
    for (int i = 0; i < NUM_IN; i++)
    begin
      cnt[i] <= (cnt[i] + 1 >= highCyc[8*i+:8] + lowCyc[8*i+:8]) ? 0 : cnt[i] + 1;
      pulseIn[i] <= cnt[i] < highCyc[8*i+:8];
    end
  end
  assign guideValid = {NUM_IN{tick == 4'hf}};
  for (genvar i = 0; i < NUM_IN; i++)
  begin : g_sensor
    logic [15:0] inv;
    assign inv = guideValid[i] ? 16'h0000 : 16'hffff;
    assign guideLeftPos[16*i+:16] = 16'(-10 * (i + 1)) ^ inv;
    assign guideRightPos[16*i+:16] = 16'(10 * (i + 1)) ^ inv;
    assign guideActivePos[16*i+:16] = 16'(5 * (i + 1)) ^ inv;
    assign guideGyro[16*i+:16] = (i == 0 ? 16'h8000 : 16'h7fff) ^ inv;
    assign guideCross[i] = crossIn[i] ^ inv[0];
    assign guideDetect[i] = ~inv[0];
    assign guideLeftMark[i] = (i % 2 == 0) ^ inv[0];
    assign guideRightMark[i] = (i % 2 == 1) ^ inv[0];
  end
endmodule : pcg_sensor_model

// ---- sim/pcg_top_tb.sv ----
// Purpose: Self-checking bench of the capture and guide readout block.
// Assumes: GATE is 400 cycles, so frequency reads edges per gate.
// Notes: Each scenario task drives the block and judges the answers.
`timescale 1ns/10ps
module pcg_top_tb
  import pcg_pkg::*;
;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [31:0] highCyc = '0;
  logic [31:0] lowCyc = '0;
  logic [3:0] crossIn = '0;
  logic [3:0] pIn, gV, gC, gD, gL, gR;
  logic [63:0] gLP, gRP, gAP, gG;
  logic [7:0] awAddr = '0;
  logic [7:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, irq;
  logic [1:0] bResp, rResp;
  logic [31:0] rData, d;
  int errCount = 0;
  int nTests = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  pcg_sensor_model src (.clk(clk), .highCyc(highCyc), .lowCyc(lowCyc), .crossIn(crossIn), .pulseIn(pIn),
    .guideValid(gV), .guideCross(gC), .guideDetect(gD), .guideLeftMark(gL), .guideRightMark(gR),
    .guideLeftPos(gLP), .guideRightPos(gRP), .guideActivePos(gAP), .guideGyro(gG));
  pcg_top #(.GATE(400)) dut (.clk(clk), .sys_rst(sysRst), .pulseIn(pIn), .guideValid(gV), .guideCross(gC),
    .guideDetect(gD), .guideLeftMark(gL), .guideRightMark(gR), .guideLeftPos(gLP), .guideRightPos(gRP),
    .guideActivePos(gAP), .guideGyro(gG), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .irq(irq));
  task automatic summarize();
    if (errCount == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do @(posedge clk); while (awReady !== 1'b1);
    awValid <= 1'b0;
    wValid <= 1'b0;
    do @(posedge clk); while (bValid !== 1'b1);
    bReady <= 1'b0;
    chk({34'h0, bResp}, {34'h0, RESP_OKAY});
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clk); while (rValid !== 1'b1);
    rReady <= 1'b0;
    d = rData;
    chk({34'h0, rResp}, {34'h0, er});
    @(posedge clk);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, RESP_OKAY);
    chk({4'h0, d}, {4'h0, exp});
  endtask : rdc
  task automatic reg_defaults();
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_RANGE, 32'h07d0_03e8);
    rdc(ADDR_GAIN, 32'h0000_0400);
    rdc(ADDR_CENTER, 32'h0000_05dc);
    rdc(ADDR_CONV0, 32'h0);
    rd(8'h3c, RESP_SLVERR);
  endtask : reg_defaults
  task automatic capture_modes();
    highCyc <= 32'h0a50_0a78;
    lowCyc <= 32'h0aa0_0a50;
    wr(ADDR_CTRL, 32'h0000_04e1);
    repeat (1000) @(posedge clk);
    rdc(ADDR_RAW0, 32'h3);
    rdc(ADDR_RAW0 + 8'h0c, 32'h14);
    rdc(ADDR_RAW0 + 8'h08, 32'h555);
    rdc(ADDR_CONV0, 32'hffff_fe0c);
    wr(ADDR_GAIN, 32'h0000_0c00);
    repeat (250) @(posedge clk);
    rdc(ADDR_CONV0, 32'hffff_fc18);
  endtask : capture_modes
  task automatic count_clear();
    logic [31:0] first;
    rd(ADDR_RAW0 + 8'h04, RESP_OKAY);
    first = d;
    repeat (100) @(posedge clk);
    rd(ADDR_RAW0 + 8'h04, RESP_OKAY);
    chk({35'h0, d > first}, 36'h1);
    wr(ADDR_CTRL, 32'h0000_04c1);
    highCyc[15:8] <= 8'h00;
    rdc(ADDR_RAW0 + 8'h04, 32'h0);
    rdc(ADDR_CONV0 + 8'h04, 32'h0);
    wr(ADDR_CTRL, 32'h0000_04e1);
    rdc(ADDR_RAW0 + 8'h04, 32'h0);
    highCyc[15:8] <= 8'h0a;
    repeat (100) @(posedge clk);
    rd(ADDR_RAW0 + 8'h04, RESP_OKAY);
    chk({35'h0, d > 0}, 36'h1);
  endtask : count_clear
  task automatic guide_single();
    wr(ADDR_CTRL, 32'h0010_0000);
    repeat (40) @(posedge clk);
    rdc(ADDR_GSTATUS, 32'h106);
    for (int k = 1; k <= 3; k++)
    begin
      wr(ADDR_SELECT, {16'h0, 8'(k), 8'h01});
      rdc(ADDR_GTRACK, k == 1 ? 32'hffff_fff6 : k == 2 ? 32'ha : 32'h5);
    end
    rdc(ADDR_GGYRO, 32'hffff_8000);
    rdc(ADDR_GCROSS, 32'h0);
  endtask : guide_single
  task automatic guide_multi();
    wr(ADDR_CTRL, 32'h0051_0000);
    wr(ADDR_IRQ_CLR, 32'h1f);
    crossIn <= 4'h4;
    repeat (40) @(posedge clk);
    chk({35'h0, irq}, 36'h0);
    wr(ADDR_IRQ_EN, 32'h10);
    chk({35'h0, irq}, 36'h1);
    wr(ADDR_SELECT, 32'h0000_0102);
    rdc(ADDR_GSTATUS, 32'h0);
    wr(ADDR_SELECT, 32'h0000_0003);
    rdc(ADDR_GSTATUS, 32'h107);
    rdc(ADDR_GGYRO, 32'h7fff);
    rdc(ADDR_GCROSS, 32'h1);
    for (int k = 1; k <= 3; k++)
    begin
      wr(ADDR_SELECT, {16'h0, 8'(6 + k), 8'h03});
      rdc(ADDR_GTRACK, k == 1 ? 32'hffff_ffe2 : k == 2 ? 32'h1e : 32'hf);
    end
    rdc(ADDR_IRQ_STAT, 32'h10);
    wr(ADDR_IRQ_CLR, 32'h10);
    rdc(ADDR_IRQ_STAT, 32'h0);
    chk({35'h0, irq}, 36'h0);
  endtask : guide_multi
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      summarize();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    reg_defaults();
    capture_modes();
    count_clear();
    guide_single();
    guide_multi();
    summarize();
  end
endmodule : pcg_top_tb
